// *** mil_interrupt_logic.sv ***
// interrupt logic: flags, enables, vectoring, return stack, wake-up
// assumes a one-cycle core handshake and ahb-lite register access
`timescale 1ns/1ps
module mil_interrupt_logic
#(
   parameter int PC_W = 13
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // event sources
   input wire logic extIrqPin,
   input wire logic [3:0] upperPortPins,
   input wire logic portRead,
   input wire logic timerRollover,
   input wire logic comparatorEvent,
   // core sequencer
   input wire logic [PC_W-1:0] corePc,
   input wire logic instrEnd,
   output logic [PC_W-1:0] pcLoad,
   output logic pcLoadValid,
   output logic nopCycle,
   output logic sleeping
);
   import mil_pkg::*;

   typedef struct packed
   {
      mil_state_e state;
      logic [7:0] ctl;
      logic cmpFlag;
      logic cmpEn;
      logic edgeSel;
      logic extPrev;
      logic [3:0] portPrev;
      logic [1:0] lat;
      logic gieDrop;
      logic [2:0] sp;
      logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
      logic [PC_W-1:0] pcOut;
      logic pcValid;
      logic nop;
      logic cmpWake;
      logic aPend;
      logic aWrite;
      logic [7:0] aIdx;
      logic [31:0] rdata;
   } mil_state_s;

   mil_state_s cur;
   mil_state_s next_cur;
   logic extEdge;
   logic portChange;
   logic pending;
   logic wakeReq;
   logic [7:0] wdat;
   logic wrCtl;
   logic wrCore;
   logic [PC_W-1:0] retPc;

   always_comb
   begin
      next_cur = cur;
      next_cur.pcValid = 1'b0;
      next_cur.nop = 1'b0;
      wdat = hwdata[7:0];
      wrCtl = cur.aPend && cur.aWrite && cur.aIdx == IDX_IRQ_CONTROL;
      wrCore = cur.aPend && cur.aWrite && cur.aIdx == IDX_CORE_CONTROL;
      retPc = cur.stack[3'(cur.sp - 3'd1)];
      // ************************************************************
      // bus data phase; software writes first, hardware sets win
      // ************************************************************
      if (cur.aPend && cur.aWrite)
      begin
         case (cur.aIdx)
            IDX_IRQ_CONTROL: next_cur.ctl = wdat;
            IDX_PERIPH_FLAGS: next_cur.cmpFlag = wdat[CMP_BIT];
            IDX_PERIPH_ENABLES: next_cur.cmpEn = wdat[CMP_BIT];
            IDX_OPTION: next_cur.edgeSel = wdat[EDGE_BIT];
            default: ;
         endcase
      end
      // software clearing the global enable opens the no-op hazard
      if (wrCtl && cur.ctl[GIE_BIT] && !wdat[GIE_BIT])
         next_cur.gieDrop = 1'b1;
      else if (instrEnd)
         next_cur.gieDrop = 1'b0;
      // ************************************************************
      // event detection; flags set regardless of enables
      // ************************************************************
      next_cur.extPrev = extIrqPin;
      // a port read holds the latch, so a change during it keeps the mismatch
      if (!portRead)
         next_cur.portPrev = upperPortPins;
      if (extEdge)
         next_cur.ctl[EXTF_BIT] = 1'b1;
      if (timerRollover)
         next_cur.ctl[TMRF_BIT] = 1'b1;
      if (portChange)
         next_cur.ctl[PORTF_BIT] = 1'b1;
      if (comparatorEvent)
      begin
         next_cur.cmpFlag = 1'b1;
         if (cur.state == MIL_SLEEP)
            next_cur.cmpWake = 1'b1;
      end
      // ************************************************************
      // sequencer
      // ************************************************************
      case (cur.state)
         MIL_RUN:
         begin
            if (cur.gieDrop && instrEnd)
               next_cur.nop = 1'b1;
            else if (pending)
            begin
               next_cur.state = MIL_WAIT;
               // request seen, wait and vector states make up the latency
               next_cur.lat = 2'(LATENCY_CYC - 3);
            end
            if (wrCore && wdat[CC_SLEEP_BIT])
               next_cur.state = MIL_SLEEP;
         end
         MIL_WAIT:
         begin
            if (!pending)
               next_cur.state = MIL_RUN;
            else if (cur.lat == 2'd0)
               next_cur.state = MIL_VECTOR;
            else
               next_cur.lat = cur.lat - 2'd1;
         end
         MIL_VECTOR:
         begin
            next_cur.ctl[GIE_BIT] = 1'b0;
            // only the pc is saved
            next_cur.stack[cur.sp] = corePc;
            next_cur.sp = cur.sp + 3'd1;
            next_cur.pcOut = IRQ_VECTOR[PC_W-1:0];
            next_cur.pcValid = 1'b1;
            next_cur.state = MIL_RUN;
         end
         MIL_SLEEP:
         begin
            if (wakeReq)
               next_cur.state = MIL_WAKE;
         end
         MIL_WAKE:
         begin
            // prefetched instruction runs first, then vector if enabled
            if (instrEnd)
               next_cur.state = cur.ctl[GIE_BIT] ? MIL_VECTOR : MIL_RUN;
         end
         default: next_cur.state = MIL_RUN;
      endcase
      if (cur.state != MIL_SLEEP && !comparatorEvent)
         next_cur.cmpWake = cur.cmpWake;
      // return instruction: pop and set global enable
      if (wrCore && wdat[CC_RETURN_BIT] && cur.state != MIL_VECTOR)
      begin
         next_cur.ctl[GIE_BIT] = 1'b1;
         next_cur.sp = cur.sp - 3'd1;
         next_cur.pcOut = retPc;
         next_cur.pcValid = 1'b1;
      end
      // ************************************************************
      // address phase capture and read data
      // ************************************************************
      next_cur.aPend = hsel && hready && htrans[1];
      next_cur.aWrite = hwrite;
      next_cur.aIdx = haddr[9:2];
      next_cur.rdata = 32'h0000_0000;
      if (hsel && hready && htrans[1] && !hwrite)
      begin
         case (haddr[9:2])
            IDX_IRQ_CONTROL: next_cur.rdata[7:0] = cur.ctl;
            IDX_PERIPH_FLAGS: next_cur.rdata[CMP_BIT] = cur.cmpFlag;
            IDX_PERIPH_ENABLES: next_cur.rdata[CMP_BIT] = cur.cmpEn;
            IDX_OPTION: next_cur.rdata[7:0] =
               {1'b1, cur.edgeSel, 6'h3F};
            IDX_CORE_STATUS: next_cur.rdata[7:0] =
               {cur.cmpWake, 2'b00, cur.state};
            default: ;
         endcase
      end
   end

   // ************************************************************
   // request gating
   // ************************************************************
   always_comb
   begin
      extEdge = cur.edgeSel ? (extIrqPin && !cur.extPrev)
                            : (!extIrqPin && cur.extPrev);
      portChange = upperPortPins != cur.portPrev;
      wakeReq = (cur.ctl[EXTIE_BIT] && cur.ctl[EXTF_BIT])
         || (cur.ctl[TMRIE_BIT] && cur.ctl[TMRF_BIT])
         || (cur.ctl[PORTIE_BIT] && cur.ctl[PORTF_BIT])
         || (cur.ctl[PERIPHERAL_IRQ_ENABLE_BIT] && cur.cmpEn && cur.cmpFlag);
      pending = cur.ctl[GIE_BIT] && wakeReq;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cur <= '0;
         cur.state <= MIL_RUN;
         cur.ctl <= IRQ_CONTROL_RST;
         cur.cmpFlag <= PERIPH_RST[CMP_BIT];
         cur.cmpEn <= PERIPH_RST[CMP_BIT];
         cur.edgeSel <= OPTION_RST[EDGE_BIT];
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign hrdata = cur.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign pcLoad = cur.pcOut;
   assign pcLoadValid = cur.pcValid;
   assign nopCycle = cur.nop;
   // one-hot sleep bit taken straight from the state flop
   assign sleeping = cur.state[3];
endmodule

// *** mil_pkg.sv ***
// constants for the microcontroller interrupt logic block
// assumes a 32-bit ahb-lite slave and a 10 MHz instruction-cycle clock
package mil_pkg;
   // ************************************************************
   // register map (printed offsets are indices, byte = 4 * index)
   // ************************************************************
   localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0B;
   localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8C;
   localparam logic [7:0] IDX_CORE_CONTROL = 8'h90;
   localparam logic [7:0] IDX_CORE_STATUS = 8'h91;
   localparam logic [7:0] IDX_OPTION = 8'h81;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int GIE_BIT = 7;
   localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
   localparam int TMRIE_BIT = 5;
   localparam int EXTIE_BIT = 4;
   localparam int PORTIE_BIT = 3;
   localparam int TMRF_BIT = 2;
   localparam int EXTF_BIT = 1;
   localparam int PORTF_BIT = 0;
   localparam int CMP_BIT = 6;
   localparam int EDGE_BIT = 6;
   // core control bits
   localparam int CC_RETURN_BIT = 0;
   localparam int CC_SLEEP_BIT = 1;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
   localparam logic [7:0] PERIPH_RST = 8'h00;
   localparam logic [7:0] OPTION_RST = 8'hFF;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int TCY_NS = 100;
   localparam int CLK_NS = 100;
   localparam int LATENCY_TCY = 3;
   localparam int LATENCY_CYC = (LATENCY_TCY * TCY_NS) / CLK_NS;
   localparam int STACK_DEPTH = 8;
   // ************************************************************
   // sequencer states
   // ************************************************************
   typedef enum logic [4:0]
   {
      MIL_RUN = 5'b00001,
      MIL_WAIT = 5'b00010,
      MIL_VECTOR = 5'b00100,
      MIL_SLEEP = 5'b01000,
      MIL_WAKE = 5'b10000
   } mil_state_e;
endpackage

// *** mil_core_model.sv ***
// core sequencer model: steps the pc and takes branches
// assumes pcLoad is valid while pcLoadValid is high
`timescale 1ns/1ps
module mil_core_model
(
   // clock, reset, pacing
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic go,
   // branch from the interrupt logic
   input wire logic [12:0] pcLoad,
   input wire logic pcLoadValid,
   output logic [12:0] corePc,
   output logic instrEnd
);
   // ********
   // sequencer
   // ********
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         corePc <= 13'h0000;
         instrEnd <= 1'b0;
      end
      else
      begin
         // a halted core keeps the return address still
         instrEnd <= go;
         if (pcLoadValid)
            corePc <= pcLoad;
         else if (instrEnd)
            corePc <= corePc + 13'h0001;
      end
   end
endmodule

// *** mil_interrupt_logic_chk.sv ***
// port checker for the interrupt logic
// assumes bind to the top module, byte address = 4 * index
`timescale 1ns/1ps
module mil_interrupt_logic_chk
#(
   parameter int PC_W = 13
)
(
   // clock, reset, bus
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // core side
   input wire logic [PC_W-1:0] pcLoad,
   input wire logic pcLoadValid,
   input wire logic nopCycle,
   input wire logic sleeping
);
   import mil_pkg::*;
   // ********
   // write tracking
   // ********
   logic wrPh;
   logic wrote;
   logic [7:0] wrIdx;
   logic retWr;
   assign retWr = wrPh && wrIdx == IDX_CORE_CONTROL && hwdata[CC_RETURN_BIT];
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wrPh <= 1'b0;
         wrIdx <= 8'h00;
         wrote <= 1'b0;
      end
      else
      begin
         wrPh <= hready ? hsel & htrans[1] & hwrite : wrPh;
         wrIdx <= hready ? haddr[9:2] : wrIdx;
         wrote <= wrote | wrPh;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_nop; nopCycle |=> !nopCycle; endproperty
   a_nop: assert property (p_nop) else $error("nop held");
   property p_nopld; nopCycle |-> !pcLoadValid; endproperty
   a_nopld: assert property (p_nopld) else $error("load in nop");
   property p_pulse; pcLoadValid |=> !pcLoadValid; endproperty
   a_pulse: assert property (p_pulse) else $error("load held");
   property p_gie; !wrote |-> !pcLoadValid; endproperty
   a_gie: assert property (p_gie) else $error("load at reset");
   property p_vec; pcLoadValid |-> pcLoad == PC_W'(IRQ_VECTOR)
      || $past(retWr) || $past(retWr, 2); endproperty
   a_vec: assert property (p_vec) else $error("bad target");
   property p_ret; retWr |-> ##[1:2] pcLoadValid; endproperty
   a_ret: assert property (p_ret) else $error("no return");
   property p_slp; sleeping |-> !pcLoadValid; endproperty
   a_slp: assert property (p_slp) else $error("load asleep");
   property p_rst; $fell(rst) |-> !pcLoadValid && !sleeping; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   c_vec: cover property (pcLoadValid && pcLoad == PC_W'(IRQ_VECTOR));
   c_nop: cover property (nopCycle);
   c_wake: cover property ($fell(sleeping));
endmodule
bind mil_interrupt_logic mil_interrupt_logic_chk #(.PC_W(PC_W)) u_chk
   (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .pcLoad(pcLoad), .pcLoadValid(pcLoadValid), .nopCycle(nopCycle),
   .sleeping(sleeping));

// *** tb.sv ***
// testbench for the interrupt logic with a core sequencer model
// assumes one-word ahb-lite transfers and a 10 MHz clock
`timescale 1ns/1ps
module tb;
   import mil_pkg::*;
   logic ref_clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b1;
   logic hready, hreadyout, pcLoadValid, nopCycle, sleeping, instrEnd;
   logic extIrqPin = 1'b0, timerRollover = 1'b0, comparatorEvent = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [3:0] upperPortPins = 4'h0;
   logic [12:0] corePc, pcLoad, keepPc;
   logic nopSeen = 1'b0;
   int badCount = 0, samplesChecked = 0, cyc = 0, n;
   localparam logic [7:0] RIDX [4] = '{IDX_IRQ_CONTROL, IDX_IRQ_CONTROL,
      IDX_IRQ_CONTROL, IDX_PERIPH_FLAGS};
   localparam logic [7:0] REXP [4] = '{8'h04, 8'h02, 8'h01, 8'h40};
   assign hready = hreadyout;
   mil_interrupt_logic dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .extIrqPin(extIrqPin),
      .upperPortPins(upperPortPins), .portRead(1'b0),
      .timerRollover(timerRollover), .comparatorEvent(comparatorEvent),
      .corePc(corePc), .instrEnd(instrEnd), .pcLoad(pcLoad),
      .pcLoadValid(pcLoadValid), .nopCycle(nopCycle), .sleeping(sleeping));
   mil_core_model core (.ref_clk(ref_clk), .rst(rst), .go(go),
      .pcLoad(pcLoad), .pcLoadValid(pcLoadValid), .corePc(corePc),
      .instrEnd(instrEnd));
   // ********
   // clock, watchdog, tasks
   // ********
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      nopSeen = nopSeen | (nopCycle === 1'b1);
      if (cyc == 2000)
      begin
         badCount++;
         results();
      end
   end
   task automatic results();
      if (badCount == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [15:0] e, g);
      samplesChecked++;
      if (g !== e)
      begin
         badCount++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h00_0000, a, 2'h0};
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h00_0000, d};
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input string s, input logic [7:0] a, e);
      bus(1'b0, a, 8'h00);
      chk(s, {8'h00, e}, rd[15:0]);
   endtask
   task automatic fire(input int k, input int w);
      timerRollover <= k == 0;
      extIrqPin <= extIrqPin ^ (k == 1);
      upperPortPins <= k == 2 ? ~upperPortPins : upperPortPins;
      comparatorEvent <= k == 3;
      @(posedge ref_clk);
      timerRollover <= 1'b0;
      comparatorEvent <= 1'b0;
      repeat (w) @(posedge ref_clk);
   endtask
   task automatic waitLoad(input int lim);
      n = 0;
      while (pcLoadValid !== 1'b1 && n < lim)
      begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   // ********
   // sequence
   // ********
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++)
      begin
         fire(i, LATENCY_CYC + 1);
         rdchk("flag", RIDX[i], REXP[i]);
         bus(1'b1, RIDX[i], 8'h00);
      end
      fire(1, 2);
      fire(2, 2);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rdchk("control", IDX_IRQ_CONTROL, 8'h00);
      rdchk("flags", IDX_PERIPH_FLAGS, 8'h00);
      rdchk("enables", IDX_PERIPH_ENABLES, 8'h00);
      rdchk("option", IDX_OPTION, 8'hFF);
      rdchk("unmapped", 8'h40, 8'h00);
      bus(1'b1, IDX_OPTION, 8'hBF);
      fire(1, 4);
      rdchk("rise", IDX_IRQ_CONTROL, 8'h00);
      fire(1, 4);
      rdchk("fall", IDX_IRQ_CONTROL, 8'h02);
      bus(1'b1, IDX_OPTION, 8'hFF);
      go <= 1'b0;
      bus(1'b1, IDX_IRQ_CONTROL, 8'hA0);
      keepPc = corePc;
      fire(0, 0);
      waitLoad(8);
      chk("latency", 16'h0001, 16'(n >= 3 && n <= 4));
      chk("vector", {3'h1, IRQ_VECTOR}, {3'h0, pcLoadValid, pcLoad});
      rdchk("entry", IDX_IRQ_CONTROL, 8'h24);
      bus(1'b1, IDX_IRQ_CONTROL, 8'h20);
      bus(1'b1, IDX_CORE_CONTROL, 8'h01);
      waitLoad(4);
      chk("return", {3'h1, keepPc}, {3'h0, pcLoadValid, pcLoad});
      rdchk("exit", IDX_IRQ_CONTROL, 8'hA0);
      waitLoad(6);
      chk("refire", 16'h0006, 16'(n));
      nopSeen = 1'b0;
      go <= 1'b1;
      bus(1'b1, IDX_IRQ_CONTROL, 8'h20);
      repeat (3) @(posedge ref_clk);
      chk("nop", 16'h0001, {15'h0000, nopSeen});
      fire(0, 0);
      waitLoad(6);
      chk("masked", 16'h0006, 16'(n));
      bus(1'b1, IDX_IRQ_CONTROL, 8'hA4);
      waitLoad(6);
      chk("pending", 16'h0001, {15'h0000, pcLoadValid});
      bus(1'b1, IDX_PERIPH_ENABLES, 8'h40);
      bus(1'b1, IDX_IRQ_CONTROL, 8'h80);
      fire(3, 0);
      waitLoad(6);
      chk("gated", 16'h0006, 16'(n));
      bus(1'b1, IDX_IRQ_CONTROL, 8'hC0);
      waitLoad(6);
      chk("periph", 16'h0001, {15'h0000, pcLoadValid});
      bus(1'b1, IDX_PERIPH_FLAGS, 8'h00);
      go <= 1'b1;
      fire(1, 2);
      fire(1, 2);
      bus(1'b1, IDX_IRQ_CONTROL, 8'h10);
      bus(1'b1, IDX_CORE_CONTROL, 8'h02);
      @(posedge ref_clk);
      chk("asleep", 16'h0001, {15'h0000, sleeping});
      fire(1, 0);
      waitLoad(8);
      chk("inline", 16'h0008, 16'(n));
      chk("awake", 16'h0000, {15'h0000, sleeping});
      fire(1, 2);
      bus(1'b1, IDX_IRQ_CONTROL, 8'h90);
      bus(1'b1, IDX_CORE_CONTROL, 8'h02);
      fire(1, 0);
      waitLoad(12);
      chk("wakevec", {3'h1, IRQ_VECTOR}, {3'h0, pcLoadValid, pcLoad});
      results();
   end
endmodule
